// File: logic/spvp_regs.svh
`ifndef SPVP_REGS_SVH
`define SPVP_REGS_SVH
// Command codes, low six bits; for the newer variant the top two bits are don't-care except begin codes.
`define SPVP_CMD_LOAD_CONFIG 6'h00
`define SPVP_CMD_LOAD_PROG 6'h02
`define SPVP_CMD_READ_PROG 6'h04
`define SPVP_CMD_INC_ADDR 6'h06
`define SPVP_CMD_BEGIN_ERASE_PROG 6'h08
`define SPVP_CMD_BEGIN_PROG_ONLY 6'h18
`define SPVP_CMD_LOAD_DATA 6'h03
`define SPVP_CMD_READ_DATA 6'h05
`define SPVP_CMD_BULK_ERASE_PROG 6'h09
`define SPVP_CMD_BULK_ERASE_DATA 6'h0b
`define SPVP_CMD_BITS 6
`define SPVP_FRAME_BITS 16
`define SPVP_WORD_BITS 14
`define SPVP_CONFIG_BASE 14'h2000
`define SPVP_ID_UPPER_PATTERN 10'h3f8
`define SPVP_CLK_HZ 200000000
// Least gap between command and data, and between commands, in ns.
`define SPVP_GAP_NS 1000
`define SPVP_GAP_CYCLES ((`SPVP_GAP_NS * (`SPVP_CLK_HZ / 1000000) + 999) / 1000)
// Half period of the generated serial clock in core cycles.
`define SPVP_HALF_CYCLES 8
`endif

// File: logic/spvp_pkg.sv
package spvp_pkg;
  typedef struct packed {
    logic [5:0] code;
    logic [13:0] wdata;
    logic has_wdata;
    logic has_rdata;
  } spvp_cmd_t;
  typedef struct packed {
    logic [13:0] rdata;
    logic done;
  } spvp_rsp_t;
endpackage

// File: logic/spvp_sync.sv
`timescale 1ns/100ps
module spvp_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_d,
  output logic o_q
);
  logic meta_reg;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= 1'b0;
      o_q <= 1'b0;
    end else begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end
endmodule // spvp_sync

// File: logic/spvp_clkgen.sv
`timescale 1ns/100ps
`include "spvp_regs.svh"
module spvp_clkgen (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_run,
  output logic o_rise,
  output logic o_fall,
  output logic o_sclk
);
  logic [3:0] cnt_reg;
  logic tick;
  assign tick = i_run && (cnt_reg == 4'(`SPVP_HALF_CYCLES - 1));
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= 4'h0;
    end else if (!i_run || tick) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sclk <= 1'b0;
    end else if (tick) begin
      o_sclk <= ~o_sclk;
    end
  end
  assign o_rise = tick && !o_sclk;
  assign o_fall = tick && o_sclk;
endmodule // spvp_clkgen

// File: logic/spvp_host.sv
`timescale 1ns/100ps
`include "spvp_regs.svh"
module spvp_host
  import spvp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_enter,
  input wire logic i_exit,
  input wire logic i_cmd_valid,
  input wire spvp_cmd_t i_cmd,
  output logic o_cmd_ready,
  output spvp_rsp_t o_rsp,
  output logic o_in_mode,
  output logic o_hv_mode_select_pin,
  output logic o_prog_serial_clock_pin,
  output logic o_prog_serial_data_pin_o,
  output logic o_prog_serial_data_pin_oe,
  input wire logic i_prog_serial_data_pin_i,
  output logic o_osc_hold
);
  typedef enum logic [2:0] {
    SPVP_OFF,
    SPVP_ENTRY,
    SPVP_IDLE,
    SPVP_CMD,
    SPVP_GAP1,
    SPVP_DATA,
    SPVP_GAP2
  } spvp_state_t;

  // ----------------------------------------------------------------
  // Pin input synchronisation
  // ----------------------------------------------------------------
  logic data_in_sync;
  spvp_sync u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d(i_prog_serial_data_pin_i),
    .o_q(data_in_sync)
  );

  // ----------------------------------------------------------------
  // Serial clock generation
  // ----------------------------------------------------------------
  logic clk_run;
  logic sclk_rise;
  logic sclk_fall;
  logic sclk;
  spvp_clkgen u_clkgen (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_run(clk_run),
    .o_rise(sclk_rise),
    .o_fall(sclk_fall),
    .o_sclk(sclk)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  spvp_state_t state_reg;
  logic [4:0] bit_reg;
  logic [7:0] gap_reg;
  logic [15:0] shift_reg;
  logic [13:0] rdata_reg;
  logic has_wdata_reg;
  logic has_rdata_reg;
  logic done_reg;
  // Command code held for the whole six-clock command.
  logic [5:0] code_reg;

  assign clk_run = (state_reg == SPVP_CMD) || (state_reg == SPVP_DATA);
  assign o_cmd_ready = (state_reg == SPVP_IDLE) && !i_exit;
  assign o_in_mode = (state_reg != SPVP_OFF);
  assign o_osc_hold = 1'b1;
  assign o_prog_serial_clock_pin = sclk;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= SPVP_OFF;
      bit_reg <= 5'h00;
      gap_reg <= 8'h00;
      has_wdata_reg <= 1'b0;
      has_rdata_reg <= 1'b0;
    end else begin
      case (state_reg)
        SPVP_OFF: begin
          if (i_enter) begin
            state_reg <= SPVP_ENTRY;
            gap_reg <= 8'h00;
          end
        end
        SPVP_ENTRY: begin
          if (gap_reg == 8'(`SPVP_GAP_CYCLES)) begin
            state_reg <= SPVP_IDLE;
          end else begin
            gap_reg <= gap_reg + 8'h01;
          end
        end
        SPVP_IDLE: begin
          if (i_exit) begin
            state_reg <= SPVP_OFF;
          end else if (i_cmd_valid) begin
            state_reg <= SPVP_CMD;
            bit_reg <= 5'h00;
            has_wdata_reg <= i_cmd.has_wdata;
            has_rdata_reg <= i_cmd.has_rdata;
          end
        end
        SPVP_CMD: begin
          if (sclk_fall) begin
            if (bit_reg == 5'(`SPVP_CMD_BITS - 1)) begin
              state_reg <= (has_wdata_reg || has_rdata_reg) ? SPVP_GAP1 : SPVP_GAP2;
              gap_reg <= 8'h00;
              bit_reg <= 5'h00;
            end else begin
              bit_reg <= bit_reg + 5'h01;
            end
          end
        end
        SPVP_GAP1: begin
          if (gap_reg == 8'(`SPVP_GAP_CYCLES)) begin
            state_reg <= SPVP_DATA;
          end else begin
            gap_reg <= gap_reg + 8'h01;
          end
        end
        SPVP_DATA: begin
          if (sclk_fall) begin
            if (bit_reg == 5'(`SPVP_FRAME_BITS - 1)) begin
              state_reg <= SPVP_GAP2;
              gap_reg <= 8'h00;
            end else begin
              bit_reg <= bit_reg + 5'h01;
            end
          end
        end
        SPVP_GAP2: begin
          if (gap_reg == 8'(`SPVP_GAP_CYCLES)) begin
            state_reg <= SPVP_IDLE;
          end else begin
            gap_reg <= gap_reg + 8'h01;
          end
        end
        default: begin
          state_reg <= SPVP_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Mode select pin
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hv_mode_select_pin <= 1'b0;
    end else begin
      o_hv_mode_select_pin <= (state_reg != SPVP_OFF) && !(state_reg == SPVP_IDLE && i_exit);
    end
  end

  // ----------------------------------------------------------------
  // Data pin drive and sampling
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      shift_reg <= 16'h0000;
      o_prog_serial_data_pin_o <= 1'b0;
      o_prog_serial_data_pin_oe <= 1'b0;
    end else if (state_reg == SPVP_IDLE && i_cmd_valid && !i_exit) begin
      // Frame is start bit, word, stop bit; the code rides in the low six bits first.
      // Full frame driven only for writes; on reads the pin is left to the target
      shift_reg <= {1'b0, i_cmd.wdata, 1'b0};
      o_prog_serial_data_pin_o <= i_cmd.code[0];
      o_prog_serial_data_pin_oe <= 1'b1;
    end else if (state_reg == SPVP_CMD && sclk_rise) begin
      o_prog_serial_data_pin_o <= code_reg[bit_reg[2:0]];
    end else if (state_reg == SPVP_GAP1) begin
      // Releasing during the gap lets the target turn the pin round for a read.
      o_prog_serial_data_pin_oe <= has_wdata_reg;
      o_prog_serial_data_pin_o <= shift_reg[0];
    end else if (state_reg == SPVP_DATA && sclk_rise && has_wdata_reg) begin
      o_prog_serial_data_pin_o <= shift_reg[bit_reg[3:0]];
    end else if (state_reg == SPVP_GAP2 || state_reg == SPVP_OFF) begin
      o_prog_serial_data_pin_oe <= 1'b0;
      o_prog_serial_data_pin_o <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      code_reg <= 6'h00;
    end else if (state_reg == SPVP_IDLE && i_cmd_valid && !i_exit) begin
      code_reg <= i_cmd.code;
    end
  end

  // Sampling on the host's falling edge sees the synchronised level, which trails the pin by
  // two core cycles; the half period of eight cycles leaves margin for that lag.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_reg <= 14'h0000;
    end else if (state_reg == SPVP_DATA && sclk_fall && has_rdata_reg) begin
      // Target drives cycles two to fifteen
      if (bit_reg >= 5'h01 && bit_reg <= 5'(`SPVP_WORD_BITS)) begin
        rdata_reg[4'(bit_reg - 5'h01)] <= data_in_sync;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (state_reg == SPVP_GAP2) && (gap_reg == 8'(`SPVP_GAP_CYCLES));
    end
  end

  assign o_rsp.rdata = rdata_reg;
  assign o_rsp.done = done_reg;

  // The caller picks codes and order: and are met by sending full codes
  // are the target's pointer rules
  // are sequences the caller must issue.
endmodule // spvp_host

// File: bench/spvp_dev_model.sv
`timescale 1ns/100ps
`include "spvp_regs.svh"
module spvp_dev_model (
  input wire logic i_hv_mode_select_pin,
  input wire logic i_sclk,
  input wire logic i_data,
  output logic o_data,
  output logic o_oe
);
  logic [13:0] pmem [0:1023];
  logic [13:0] cmem [0:15];
  logic [7:0] dmem [0:63];
  logic [13:0] pc, word, sh;
  logic [5:0] cmd;
  logic [1:0] st;
  logic dsp;
  int n, r;
  initial begin
    for (int i = 0; i < 1024; i++) begin
      pmem[i] = 14'h3fff;
      cmem[i % 16] = 14'h3fff;
      dmem[i % 64] = 8'hff;
    end
    o_data = 1'b0;
    o_oe = 1'b0;
  end
  always @(negedge i_sclk or negedge i_hv_mode_select_pin) begin
    if (!i_hv_mode_select_pin) begin
      pc = 14'h0;
      st = 2'h0;
      n = 0;
    end else if (st == 2'h0) begin
      cmd = {i_data, cmd[5:1]};
      n = n + 1;
      if (n == 6) begin
        n = 0;
        st = (cmd inside {`SPVP_CMD_LOAD_CONFIG, `SPVP_CMD_LOAD_PROG, `SPVP_CMD_LOAD_DATA}) ? 2'h1 :
          (cmd inside {`SPVP_CMD_READ_PROG, `SPVP_CMD_READ_DATA}) ? 2'h2 : 2'h0;
        if (st != 2'h0) dsp = cmd[0];
        if (cmd == `SPVP_CMD_LOAD_CONFIG) pc = `SPVP_CONFIG_BASE;
        if (cmd == `SPVP_CMD_INC_ADDR) pc = {pc[13], pc[12:0] + 13'h1};
        if (cmd inside {`SPVP_CMD_BEGIN_ERASE_PROG, `SPVP_CMD_BEGIN_PROG_ONLY}) begin
          if (dsp) dmem[pc[5:0]] = sh[7:0];
          else if (pc[13]) cmem[pc[3:0]] = sh;
          else pmem[pc[9:0]] = sh;
        end
        word = dsp ? {6'h00, dmem[pc[5:0]]} : pc[13] ? cmem[pc[3:0]] : pmem[pc[9:0]];
      end
    end else begin
      n = n + 1;
      if (st == 2'h1 && n >= 2 && n <= 15) sh[n - 2] = i_data;
      if (n == 16) begin
        n = 0;
        st = 2'h0;
      end
    end
  end
  always @(posedge i_sclk or negedge i_hv_mode_select_pin) begin
    if (!i_hv_mode_select_pin || st != 2'h2) r = 0;
    else r = r + 1;
    // A released line shows the inverse so a stale bit cannot pass.
    if (r >= 2 && r <= 15) begin
      o_oe = 1'b1;
      o_data = word[r - 2];
    end else if (o_oe) begin
      o_oe = 1'b0;
      o_data = ~o_data;
    end
  end
endmodule // spvp_dev_model

// File: bench/spvp_host_sva.sv
`timescale 1ns/100ps
module spvp_host_sva
  import spvp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_exit,
  input wire logic i_cmd_valid,
  input wire logic o_cmd_ready,
  input wire spvp_rsp_t o_rsp,
  input wire logic o_hv_mode_select_pin,
  input wire logic o_prog_serial_clock_pin,
  input wire logic o_prog_serial_data_pin_o,
  input wire logic o_prog_serial_data_pin_oe,
  input wire logic o_osc_hold
);
  logic sk, dq, de, hv;
  logic [7:0] lo_cnt;
  logic [4:0] burst;
  assign sk = o_prog_serial_clock_pin;
  assign dq = o_prog_serial_data_pin_o;
  assign de = o_prog_serial_data_pin_oe;
  assign hv = o_hv_mode_select_pin;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) lo_cnt <= 8'h00;
    else if (sk) lo_cnt <= 8'h00;
    else if (lo_cnt != 8'hff) lo_cnt <= lo_cnt + 8'h01;
  end
  // Counts rising edges of one burst, restarted after every long gap.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) burst <= 5'h00;
    else if (sk && lo_cnt != 8'h00) burst <= (lo_cnt >= 8'd200) ? 5'h01 : burst + 5'h01;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  entry_pins_a: assert property ($rose(hv) |-> !sk && !dq) else $error("entry with lines high");
  off_quiet_a: assert property (!hv |-> !sk) else $error("clock runs outside mode");
  high_half_a: assert property ($rose(sk) |-> sk [*8] ##1 !sk) else $error("clock high half wrong");
  low_half_a: assert property ($fell(sk) |-> !sk [*8]) else $error("clock low half short");
  gap_a: assert property ($rose(sk) |-> lo_cnt == 8'd8 || lo_cnt >= 8'd200) else $error("gap short");
  frame_len_a: assert property (!sk && lo_cnt == 8'd9 && burst != 5'h00 |-> burst == 5'd6 || burst == 5'd16)
    else $error("burst length wrong");
  data_hold_a: assert property ($past(sk) && de && $past(de) |-> $stable(dq)) else $error("data moved");
  osc_hold_a: assert property (o_osc_hold) else $error("oscillator not held");
  take_once_a: assert property (i_cmd_valid && o_cmd_ready |=> !o_cmd_ready) else $error("taken twice");
  done_pulse_a: assert property (o_rsp.done |=> !o_rsp.done) else $error("done too long");
  exit_drop_a: assert property ($rose(i_exit) && hv |-> ##[1:1000] !hv) else $error("select stays");
  cover property ($rose(hv));
  cover property (!sk && lo_cnt == 8'd9 && burst == 5'd16);
  cover property ($fell(hv));
endmodule // spvp_host_sva
bind spvp_host spvp_host_sva u_sva (.i_clk(i_clk), .i_rst(i_rst), .i_exit(i_exit), .i_cmd_valid(i_cmd_valid),
  .o_cmd_ready(o_cmd_ready), .o_rsp(o_rsp), .o_hv_mode_select_pin(o_hv_mode_select_pin),
  .o_prog_serial_clock_pin(o_prog_serial_clock_pin), .o_prog_serial_data_pin_o(o_prog_serial_data_pin_o),
  .o_prog_serial_data_pin_oe(o_prog_serial_data_pin_oe), .o_osc_hold(o_osc_hold));

// File: bench/serial_program_verify_port_tb.sv
`timescale 1ns/100ps
`include "spvp_regs.svh"
module serial_program_verify_port_tb
  import spvp_pkg::*;
();
  logic clk, rst, ent, lv, vld, rdy, inm, hv, sk, ho, hoe, osc, dmo, dmoe, pin;
  spvp_cmd_t cmd;
  spvp_rsp_t rsp;
  int n_errors = 0;
  int checks = 0;
  assign pin = dmoe ? dmo : hoe ? ho : dmo;
  spvp_host u_dut (.i_clk(clk), .i_rst(rst), .i_enter(ent), .i_exit(lv), .i_cmd_valid(vld), .i_cmd(cmd),
    .o_cmd_ready(rdy), .o_rsp(rsp), .o_in_mode(inm), .o_hv_mode_select_pin(hv), .o_prog_serial_clock_pin(sk),
    .o_prog_serial_data_pin_o(ho), .o_prog_serial_data_pin_oe(hoe), .i_prog_serial_data_pin_i(pin),
    .o_osc_hold(osc));
  spvp_dev_model u_dev (.i_hv_mode_select_pin(hv), .i_sclk(sk), .i_data(pin), .o_data(dmo), .o_oe(dmoe));
  task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wait_ready();
    for (int t = 0; t < 999 && rdy !== 1'b1; t++) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic xfer(input logic [5:0] c, input logic [13:0] w, input logic [1:0] k);
    wait_ready();
    @(posedge clk);
    vld <= 1'b1;
    cmd <= '{c, w, k[1], k[0]};
    @(posedge clk);
    vld <= 1'b0;
    for (int t = 0; t < 999 && rsp.done !== 1'b1; t++) begin
      @(posedge clk);
      #1;
    end
    chk("done", 14'h1, {13'h0, rsp.done});
  endtask
  task automatic enter();
    @(posedge clk);
    ent <= 1'b1;
    @(posedge clk);
    ent <= 1'b0;
    wait_ready();
    chk("in_mode", 14'h1, {13'h0, inm});
  endtask
  task automatic t_prog();
    enter();
    xfer(`SPVP_CMD_LOAD_PROG, 14'h2a5c, 2'b10);
    xfer(`SPVP_CMD_BEGIN_ERASE_PROG, 14'h0, 2'b00);
    xfer(`SPVP_CMD_READ_PROG, 14'h0, 2'b01);
    chk("prog_word", 14'h2a5c, rsp.rdata);
    xfer(`SPVP_CMD_INC_ADDR, 14'h0, 2'b00);
    xfer(`SPVP_CMD_READ_PROG, 14'h0, 2'b01);
    chk("next_word", 14'h3fff, rsp.rdata);
  endtask
  task automatic t_data();
    xfer(`SPVP_CMD_LOAD_DATA, 14'h3f5a, 2'b10);
    xfer(`SPVP_CMD_BEGIN_ERASE_PROG, 14'h0, 2'b00);
    xfer(`SPVP_CMD_READ_DATA, 14'h0, 2'b01);
    chk("data_byte", 14'h005a, {6'h00, rsp.rdata[7:0]});
  endtask
  task automatic t_cfg();
    xfer(`SPVP_CMD_LOAD_CONFIG, {`SPVP_ID_UPPER_PATTERN, 4'h5}, 2'b10);
    xfer(`SPVP_CMD_BEGIN_PROG_ONLY, 14'h0, 2'b00);
    xfer(`SPVP_CMD_READ_PROG, 14'h0, 2'b01);
    chk("id_word", 14'h3f85, rsp.rdata);
    xfer(`SPVP_CMD_INC_ADDR, 14'h0, 2'b00);
    xfer(`SPVP_CMD_READ_PROG, 14'h0, 2'b01);
    chk("cfg_next", 14'h3fff, rsp.rdata);
    wait_ready();
    @(posedge clk);
    lv <= 1'b1;
    repeat (20) @(posedge clk);
    lv <= 1'b0;
    chk("select_low", 14'h0, {13'h0, hv});
    chk("in_mode_off", 14'h0, {13'h0, inm});
    enter();
    xfer(`SPVP_CMD_READ_PROG, 14'h0, 2'b01);
    chk("user_again", 14'h2a5c, rsp.rdata);
  endtask
  always @(posedge clk) begin
    if (dmoe === 1'b1 && hoe === 1'b1) begin
      n_errors++;
      $display("mismatch data_drivers expected %h seen %h", 1'b0, hoe);
    end
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    ent = 1'b0;
    lv = 1'b0;
    vld = 1'b0;
    cmd = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_prog();
    t_data();
    t_cfg();
    report_and_stop();
  end
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
endmodule // serial_program_verify_port_tb
